// ### include/tev_pkg.sv
package tev_pkg;

  localparam int TEV_DW = 16;
  localparam int TEV_AW = 6;

  localparam logic [TEV_AW-1:0] ADDR_TAP_THRESHOLD = 6'h1d;
  localparam logic [TEV_AW-1:0] ADDR_TAP_MAX_DURATION = 6'h21;
  localparam logic [TEV_AW-1:0] ADDR_TAP_LATENCY = 6'h22;
  localparam logic [TEV_AW-1:0] ADDR_TAP_SECOND_WINDOW = 6'h23;
  localparam logic [TEV_AW-1:0] ADDR_TAP_AXIS_CONTROL = 6'h2a;
  localparam logic [TEV_AW-1:0] ADDR_TAP_FIRST_AXIS_STATUS = 6'h2b;
  localparam logic [TEV_AW-1:0] ADDR_OUTPUT_RATE_CONFIG = 6'h2c;
  localparam logic [TEV_AW-1:0] ADDR_INTERRUPT_ENABLE_MASK = 6'h2e;
  localparam logic [TEV_AW-1:0] ADDR_TAP_SIGN = 6'h3a;

  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] RDATA_UNMAPPED = 8'h00;

  // Axis vectors are indexed x = 2, y = 1, z = 0 throughout.
  localparam int AXC_SUPPRESS_BIT = 3;
  localparam int AXC_IMPROVED_BIT = 4;
  localparam int IEN_SINGLE_BIT = 6;
  localparam int IEN_DOUBLE_BIT = 5;
  localparam int SIGN_FIELD_LSB = 4;
  localparam int FIRST_FIELD_LSB = 0;

  localparam logic [7:0] CNT_ZERO = 8'h00;
  localparam logic [7:0] CNT_ONE = 8'h01;

  typedef struct packed {
    logic signed [TEV_DW-1:0] x;
    logic signed [TEV_DW-1:0] y;
    logic signed [TEV_DW-1:0] z;
  } tev_axes_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [TEV_AW-1:0] addr;
    logic [7:0] wdata;
  } tev_reg_req_t;

  typedef enum logic [5:0] {
    ST_IDLE = 6'b00_0001,
    ST_TAP1 = 6'b00_0010,
    ST_HOLD = 6'b00_0100,
    ST_LAT = 6'b00_1000,
    ST_WIN = 6'b01_0000,
    ST_TAP2 = 6'b10_0000
  } tev_state_t;

endpackage

// ### rtl/tev_tap_detector.sv
`timescale 1ns/1ps
module tev_tap_detector
  import tev_pkg::*;
#(
  parameter int THR_SHIFT = 4
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire tev_reg_req_t reg_req,
  output logic [7:0] reg_rdata_ff,
  input wire logic raw_valid,
  input wire tev_axes_t raw_sample,
  input wire logic odr_valid,
  input wire tev_axes_t odr_sample,
  output logic [7:0] output_rate_config_ff,
  output logic single_tap_evt_ff,
  output logic double_tap_evt_ff
);

  if (THR_SHIFT < 0 || THR_SHIFT + 8 > TEV_DW) begin : g_bad_shift
    $error("THR_SHIFT does not fit the sample width");
  end

  logic [7:0] tap_threshold_ff;
  logic [7:0] tap_max_duration_ff;
  logic [7:0] tap_latency_ff;
  logic [7:0] tap_second_window_ff;
  logic [7:0] tap_axis_control_ff;
  logic [7:0] interrupt_enable_mask_ff;
  logic [2:0] first_axis_ff;
  logic [2:0] tap_sign_ff;
  logic [2:0] cand_axis_ff;
  logic [2:0] cand_sign_ff;
  tev_axes_t prev_odr_ff;
  tev_state_t state_ff;
  tev_state_t nxt_state;
  logic [7:0] cnt_ff;
  logic [7:0] nxt_cnt;
  logic go_single;
  logic go_double;
  logic capture;

  // Register port decode.
  wire wr_thr = reg_req.wr && reg_req.addr == ADDR_TAP_THRESHOLD;
  wire wr_dur = reg_req.wr && reg_req.addr == ADDR_TAP_MAX_DURATION;
  wire wr_lat = reg_req.wr && reg_req.addr == ADDR_TAP_LATENCY;
  wire wr_win = reg_req.wr && reg_req.addr == ADDR_TAP_SECOND_WINDOW;
  wire wr_axc = reg_req.wr && reg_req.addr == ADDR_TAP_AXIS_CONTROL;
  wire wr_rate = reg_req.wr && reg_req.addr == ADDR_OUTPUT_RATE_CONFIG;
  wire wr_ien = reg_req.wr && reg_req.addr == ADDR_INTERRUPT_ENABLE_MASK;

  wire [7:0] status_word = {5'h00, first_axis_ff} << FIRST_FIELD_LSB;
  wire [7:0] sign_word = ({5'h00, tap_sign_ff} << SIGN_FIELD_LSB)
                         | ({5'h00, first_axis_ff} << FIRST_FIELD_LSB);
  wire [7:0] rd_mux =
    (reg_req.addr == ADDR_TAP_THRESHOLD) ? tap_threshold_ff :
    (reg_req.addr == ADDR_TAP_MAX_DURATION) ? tap_max_duration_ff :
    (reg_req.addr == ADDR_TAP_LATENCY) ? tap_latency_ff :
    (reg_req.addr == ADDR_TAP_SECOND_WINDOW) ? tap_second_window_ff :
    (reg_req.addr == ADDR_TAP_AXIS_CONTROL) ? tap_axis_control_ff :
    (reg_req.addr == ADDR_TAP_FIRST_AXIS_STATUS) ? status_word :
    (reg_req.addr == ADDR_OUTPUT_RATE_CONFIG) ? output_rate_config_ff :
    (reg_req.addr == ADDR_INTERRUPT_ENABLE_MASK) ? interrupt_enable_mask_ff :
    (reg_req.addr == ADDR_TAP_SIGN) ? sign_word : RDATA_UNMAPPED;

  // Control fields.
  wire [2:0] axis_en = tap_axis_control_ff[2:0];
  wire suppress = tap_axis_control_ff[AXC_SUPPRESS_BIT];
  wire improved = tap_axis_control_ff[AXC_IMPROVED_BIT];
  wire sgl_en = interrupt_enable_mask_ff[IEN_SINGLE_BIT];
  wire dbl_en = interrupt_enable_mask_ff[IEN_DOUBLE_BIT];
  // A zero latency or window leaves double tap inoperative.
  wire dbl_armed = dbl_en && tap_latency_ff != CNT_ZERO
                   && tap_second_window_ff != CNT_ZERO;

  // Timers advance once per sample of the evaluated stream.
  wire tick = improved ? odr_valid : raw_valid;

  logic signed [TEV_DW-1:0] raw_arr [3];
  logic signed [TEV_DW-1:0] odr_arr [3];
  logic signed [TEV_DW-1:0] prev_arr [3];
  logic signed [TEV_DW-1:0] val_arr [3];
  logic [TEV_DW-1:0] mag_arr [3];
  logic [2:0] neg;
  logic [2:0] above;

  assign raw_arr[2] = raw_sample.x;
  assign raw_arr[1] = raw_sample.y;
  assign raw_arr[0] = raw_sample.z;
  assign odr_arr[2] = odr_sample.x;
  assign odr_arr[1] = odr_sample.y;
  assign odr_arr[0] = odr_sample.z;
  assign prev_arr[2] = prev_odr_ff.x;
  assign prev_arr[1] = prev_odr_ff.y;
  assign prev_arr[0] = prev_odr_ff.z;

  wire [TEV_DW-1:0] thr_ext = TEV_DW'(tap_threshold_ff) << THR_SHIFT;

  for (genvar i = 0; i < 3; i++) begin : g_axis
    // The difference wraps on overflow; tap thresholds sit far below it.
    assign val_arr[i] = improved ? TEV_DW'(odr_arr[i] - prev_arr[i])
                                 : raw_arr[i];
    assign neg[i] = val_arr[i][TEV_DW-1];
    assign mag_arr[i] = neg[i] ? TEV_DW'(-val_arr[i]) : TEV_DW'(val_arr[i]);
    assign above[i] = axis_en[i] && (mag_arr[i] > thr_ext);
  end

  wire any_above = |above;
  // The x axis wins a tie between axes crossing on the same sample.
  wire [2:0] first_pick = above[2] ? 3'b100 :
                          above[1] ? 3'b010 :
                          above[0] ? 3'b001 : 3'b000;
  wire [8:0] cnt_inc = {1'b0, cnt_ff} + 9'h001;
  wire dur_over = cnt_ff >= tap_max_duration_ff;
  wire lat_done = cnt_inc >= {1'b0, tap_latency_ff};
  wire win_done = cnt_inc >= {1'b0, tap_second_window_ff};

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    go_single = 1'b0;
    go_double = 1'b0;
    capture = 1'b0;
    if (tick) begin
      case (state_ff)
        ST_IDLE: begin
          if (any_above) begin
            capture = 1'b1;
            nxt_cnt = CNT_ONE;
            nxt_state = ST_TAP1;
          end
        end
        ST_TAP1: begin
          if (any_above) begin
            if (dur_over) begin
              nxt_state = ST_HOLD;
            end else begin
              nxt_cnt = cnt_inc[7:0];
            end
          end else if (dbl_armed) begin
            nxt_cnt = CNT_ZERO;
            nxt_state = ST_LAT;
          end else begin
            go_single = sgl_en;
            nxt_state = ST_IDLE;
          end
        end
        ST_HOLD: begin
          // A too-long excursion must end before a new tap can start.
          if (!any_above) begin
            nxt_state = ST_IDLE;
          end
        end
        ST_LAT: begin
          if (suppress && any_above) begin
            go_single = sgl_en;
            nxt_state = ST_IDLE;
          end else if (lat_done) begin
            nxt_cnt = CNT_ZERO;
            nxt_state = ST_WIN;
          end else begin
            nxt_cnt = cnt_inc[7:0];
          end
        end
        ST_WIN: begin
          if (any_above && cnt_ff == CNT_ZERO) begin
            go_single = sgl_en;
            nxt_state = ST_IDLE;
          end else if (any_above) begin
            nxt_cnt = CNT_ONE;
            nxt_state = ST_TAP2;
          end else if (win_done) begin
            go_single = sgl_en;
            nxt_state = ST_IDLE;
          end else begin
            nxt_cnt = cnt_inc[7:0];
          end
        end
        ST_TAP2: begin
          if (any_above && dur_over) begin
            go_single = sgl_en;
            nxt_state = ST_IDLE;
          end else if (any_above) begin
            nxt_cnt = cnt_inc[7:0];
          end else begin
            go_double = dbl_en;
            go_single = sgl_en;
            nxt_state = ST_IDLE;
          end
        end
        default: begin
          nxt_state = ST_IDLE;
        end
      endcase
    end
  end

  wire evt_go = go_single || go_double;
  // Sign bits of disabled axes are kept; their first-axis bits clear.
  wire [2:0] nxt_sign = (tap_sign_ff & ~axis_en)
                        | (cand_sign_ff & axis_en);
  wire [2:0] nxt_first = cand_axis_ff & axis_en;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      tap_threshold_ff <= REG_RESET;
      tap_max_duration_ff <= REG_RESET;
      tap_latency_ff <= REG_RESET;
      tap_second_window_ff <= REG_RESET;
      tap_axis_control_ff <= REG_RESET;
      output_rate_config_ff <= REG_RESET;
      interrupt_enable_mask_ff <= REG_RESET;
      reg_rdata_ff <= RDATA_UNMAPPED;
    end else begin
      if (wr_thr) tap_threshold_ff <= reg_req.wdata;
      if (wr_dur) tap_max_duration_ff <= reg_req.wdata;
      if (wr_lat) tap_latency_ff <= reg_req.wdata;
      if (wr_win) tap_second_window_ff <= reg_req.wdata;
      if (wr_axc) tap_axis_control_ff <= reg_req.wdata;
      if (wr_rate) output_rate_config_ff <= reg_req.wdata;
      if (wr_ien) interrupt_enable_mask_ff <= reg_req.wdata;
      if (reg_req.rd) reg_rdata_ff <= rd_mux;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_ff <= ST_IDLE;
      cnt_ff <= CNT_ZERO;
      prev_odr_ff <= '0;
      cand_axis_ff <= 3'b000;
      cand_sign_ff <= 3'b000;
      first_axis_ff <= 3'b000;
      tap_sign_ff <= 3'b000;
      single_tap_evt_ff <= 1'b0;
      double_tap_evt_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      if (odr_valid) prev_odr_ff <= odr_sample;
      if (capture) cand_axis_ff <= first_pick;
      if (capture) cand_sign_ff <= neg & first_pick;
      if (evt_go) first_axis_ff <= nxt_first;
      if (evt_go) tap_sign_ff <= nxt_sign;
      single_tap_evt_ff <= go_single;
      double_tap_evt_ff <= go_double;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  property p_double_enabled;
    double_tap_evt_ff |-> $past(dbl_en) && $past(state_ff) == ST_TAP2;
  endproperty
  a_double_enabled: assert property (p_double_enabled)
    else $error("double tap event while disabled or out of sequence");

  property p_single_enabled;
    single_tap_evt_ff |-> $past(sgl_en);
  endproperty
  a_single_enabled: assert property (p_single_enabled)
    else $error("single tap event while disabled");

  property p_first_tap;
    state_ff == ST_IDLE && tick && any_above |=> state_ff == ST_TAP1
      && cnt_ff == CNT_ONE;
  endproperty
  a_first_tap: assert property (p_first_tap)
    else $error("threshold crossing did not start a tap");

  property p_too_long;
    state_ff == ST_TAP1 && tick && any_above && dur_over
      |=> state_ff == ST_HOLD && !single_tap_evt_ff;
  endproperty
  a_too_long: assert property (p_too_long)
    else $error("overlong excursion accepted as tap");

  property p_single_now;
    state_ff == ST_TAP1 && tick && !any_above && !dbl_armed && sgl_en
      |=> single_tap_evt_ff ##1 !single_tap_evt_ff;
  endproperty
  a_single_now: assert property (p_single_now)
    else $error("single tap not reported at tap end");

  property p_single_waits;
    state_ff == ST_TAP1 && tick && !any_above && dbl_armed
      |=> state_ff == ST_LAT && !single_tap_evt_ff;
  endproperty
  a_single_waits: assert property (p_single_waits)
    else $error("single tap reported before double tap outcome");

  property p_suppress;
    state_ff == ST_LAT && tick && any_above && suppress
      |=> state_ff == ST_IDLE && !double_tap_evt_ff;
  endproperty
  a_suppress: assert property (p_suppress)
    else $error("latency spike did not cancel double tap");

  property p_window_open_high;
    state_ff == ST_WIN && tick && any_above && cnt_ff == CNT_ZERO
      |=> state_ff == ST_IDLE ##1 !double_tap_evt_ff;
  endproperty
  a_window_open_high: assert property (p_window_open_high)
    else $error("window opened above threshold without invalidation");

  property p_second_too_long;
    state_ff == ST_TAP2 && tick && any_above && dur_over
      |=> state_ff == ST_IDLE && single_tap_evt_ff == $past(sgl_en)
      ##1 !double_tap_evt_ff;
  endproperty
  a_second_too_long: assert property (p_second_too_long)
    else $error("overlong second tap not invalidated");

  property p_status_hold;
    !(single_tap_evt_ff || double_tap_evt_ff) |-> $stable(first_axis_ff)
      && $stable(tap_sign_ff);
  endproperty
  a_status_hold: assert property (p_status_hold)
    else $error("tap status changed without a tap event");

  property p_status_axes;
    (single_tap_evt_ff || double_tap_evt_ff)
      |-> (first_axis_ff & ~$past(axis_en)) == 3'b000
      && $onehot0(first_axis_ff);
  endproperty
  a_status_axes: assert property (p_status_axes)
    else $error("first axis names a disabled axis");

  c_single: cover property (single_tap_evt_ff && !double_tap_evt_ff);
  c_double: cover property (double_tap_evt_ff);
  c_suppress: cover property (state_ff == ST_LAT && tick && any_above
    && suppress);
  c_improved: cover property (improved && state_ff == ST_TAP1);

endmodule

// ### verification/tap_event_detector_tb.sv
`timescale 1ns/1ps
module tap_event_detector_tb
  import tev_pkg::*;
;
  localparam logic [7:0] THR = 8'h31;
  logic core_clk = 1'h0;
  logic sys_rst = 1'h1;
  tev_reg_req_t req = '0;
  logic raw_valid = 1'h0;
  logic odr_valid = 1'h0;
  tev_axes_t raw_s = '0;
  tev_axes_t odr_s = '0;
  tev_axes_t last_odr = '0;
  logic [7:0] rdata;
  logic [7:0] rate_cfg;
  logic single_evt;
  logic double_evt;
  logic imp = 1'h0;
  logic rdp;
  logic [2:0] sgn = 3'h0;
  logic [2:0] flg = 3'h0;
  logic [31:0] cyc = 32'h0000_0000;
  int bad_count = 0;
  int total_checks = 0;
  logic [7:0] rd_q[$];
  logic [33:0] evt_q[$];

  tev_tap_detector u_dut (
    .core_clk(core_clk), .sys_rst(sys_rst), .reg_req(req),
    .reg_rdata_ff(rdata), .raw_valid(raw_valid), .raw_sample(raw_s),
    .odr_valid(odr_valid), .odr_sample(odr_s),
    .output_rate_config_ff(rate_cfg), .single_tap_evt_ff(single_evt),
    .double_tap_evt_ff(double_evt)
  );

  initial begin
    forever #50 core_clk = ~core_clk;
  end

  task automatic cmp_reg(input string nm, input logic [7:0] ex,
                         input logic [7:0] got);
    total_checks++;
    if (got !== ex) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, ex, got);
    end
  endtask

  // Event notes carry the cycle they must appear in, so early or late
  // pulses fail as surely as missing ones.
  task automatic cmp_evt(input string nm, input logic [33:0] ex,
                         input logic [33:0] got);
    total_checks++;
    if (got !== ex) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, ex, got);
    end
  endtask

  always @(posedge core_clk) begin
    rdp = req.rd;
    cyc = cyc + 32'h0000_0001;
    #1;
    if (rdp === 1'h1)
      cmp_reg("read data", rd_q.size() ? rd_q.pop_front() : 8'hxx, rdata);
    if (single_evt !== 1'h0 || double_evt !== 1'h0)
      cmp_evt("tap event", evt_q.size() ? evt_q.pop_front() :
              34'h0_0000_0000, {cyc, single_evt, double_evt});
  end

  function automatic tev_axes_t junk();
    junk = {16'($urandom), 16'($urandom), 16'($urandom)};
  endfunction

  function automatic logic [15:0] hi(input logic ng);
    logic [15:0] m;
    m = {4'h0, THR, 4'h0} + 16'h0001 + 16'($urandom_range(0, 1000));
    return ng ? -m : m;
  endfunction

  function automatic logic [15:0] lo();
    lo = 16'($urandom_range(0, 600)) - 16'h012C;
  endfunction

  task automatic step(input tev_reg_req_t r, input logic rv, input logic ov,
                      input tev_axes_t rs, input tev_axes_t os);
    @(negedge core_clk);
    req = r;
    raw_valid = rv;
    odr_valid = ov;
    raw_s = rs;
    odr_s = os;
    if (ov)
      last_odr = os;
  endtask

  task automatic acc(input logic w, input logic [TEV_AW-1:0] a,
                     input logic [7:0] d);
    step('{w, ~w, a, d}, 1'h0, 1'h0, junk(), junk());
    if (!w)
      rd_q.push_back(d);
  endtask

  // The unused stream always carries junk, so reading the wrong one
  // produces stray events.
  task automatic samp(input logic [15:0] x, input logic [15:0] y,
                      input logic [15:0] z, input logic [1:0] e);
    tev_axes_t o;
    if ($urandom_range(0, 3) == 0)
      step('0, 1'h0, 1'h0, junk(), junk());
    o = junk();
    if (imp) begin
      o.x = last_odr.x + x;
      o.y = last_odr.y + y;
      o.z = last_odr.z + z;
      step('0, 1'h1, 1'h1, junk(), o);
    end else begin
      step('0, 1'h1, 1'($urandom), {x, y, z}, o);
    end
    if (e != 2'h0)
      evt_q.push_back({cyc + 32'h0000_0001, e});
  endtask

  task automatic tap(input logic [2:0] m, input logic ng, input int n,
                     input logic [1:0] e, input int ep);
    logic [2:0] a;
    for (int i = 0; i <= n; i++) begin
      a = (i < n) ? m : 3'h0;
      samp(a[2] ? hi(ng) : lo(), a[1] ? hi(ng) : lo(),
           a[0] ? hi(ng) : lo(), i == ep ? e : 2'h0);
    end
  endtask

  task automatic quiet(input int n);
    repeat (n) samp(lo(), lo(), lo(), 2'h0);
  endtask

  task automatic chk(input logic [2:0] f);
    acc(1'h0, ADDR_TAP_FIRST_AXIS_STATUS, {5'h00, f});
    acc(1'h0, ADDR_TAP_SIGN, {1'h0, sgn, 1'h0, f});
  endtask

  task automatic cfg(input logic [7:0] c, input logic [7:0] en,
                     input logic [7:0] lat);
    acc(1'h1, ADDR_TAP_THRESHOLD, THR);
    acc(1'h1, ADDR_TAP_MAX_DURATION, 8'h04);
    acc(1'h1, ADDR_TAP_LATENCY, lat);
    acc(1'h1, ADDR_TAP_SECOND_WINDOW, 8'h03);
    acc(1'h1, ADDR_TAP_AXIS_CONTROL, c);
    acc(1'h1, ADDR_INTERRUPT_ENABLE_MASK, en);
    imp = c[AXC_IMPROVED_BIT];
  endtask

  task automatic tend(input string nm);
    repeat (4) step('0, 1'h0, 1'h0, junk(), junk());
    total_checks++;
    if (evt_q.size() != 0) begin
      bad_count++;
      $display("Error pending events expected 0 seen %0d", evt_q.size());
      evt_q.delete();
    end
    $display("test %s done", nm);
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    #(100 * 30000);
    $display("Error watchdog expected finish seen timeout");
    bad_count++;
    close_out();
  end

  initial begin
    logic [TEV_AW-1:0] al [9] = '{ADDR_TAP_THRESHOLD, ADDR_TAP_MAX_DURATION,
      ADDR_TAP_LATENCY, ADDR_TAP_SECOND_WINDOW, ADDR_TAP_AXIS_CONTROL,
      ADDR_OUTPUT_RATE_CONFIG, ADDR_INTERRUPT_ENABLE_MASK,
      ADDR_TAP_FIRST_AXIS_STATUS, ADDR_TAP_SIGN};
    logic [7:0] en_t [5] = '{8'h40, 8'h20, 8'h60, 8'h00, 8'h60};
    logic [7:0] lt_t [5] = '{8'h02, 8'h02, 8'h02, 8'h02, 8'h00};
    logic [1:0] a_t [5] = '{2'h2, 2'h0, 2'h0, 2'h0, 2'h2};
    logic [1:0] b_t [5] = '{2'h2, 2'h1, 2'h3, 2'h0, 2'h2};
    logic [7:0] v;
    logic [2:0] m;
    logic ng;
    int k;
    void'($urandom(12178));
    repeat (4) @(negedge core_clk);
    sys_rst = 1'h0;
    foreach (al[i]) acc(1'h0, al[i], REG_RESET);
    acc(1'h0, 6'h3f, RDATA_UNMAPPED);
    for (int i = 0; i < 7; i++) begin
      v = 8'($urandom);
      acc(1'h1, al[i], v);
      acc(1'h0, al[i], v);
    end
    acc(1'h1, al[7], 8'hFF);
    acc(1'h1, al[8], 8'hFF);
    chk(3'h0);
    acc(1'h1, ADDR_OUTPUT_RATE_CONFIG, 8'hA5);
    step('0, 1'h0, 1'h0, junk(), junk());
    cmp_reg("rate config port", 8'hA5, rate_cfg);
    tend("registers");
    cfg(8'h07, 8'h40, 8'h02);
    for (k = 0; k < 3; k++) begin
      ng = 1'($urandom);
      m = 3'h1 << k;
      // Every enabled axis other than the first one reports a zero sign.
      sgn = 3'h0;
      sgn[k] = ng;
      tap(m, ng, 4, 2'h2, 4);
      chk(m);
      tap(m, ~ng, 5, 2'h0, 0);
      chk(m);
    end
    tend("single taps");
    cfg(8'h03, 8'h40, 8'h02);
    tap(3'h4, 1'h1, 2, 2'h0, 0);
    ng = 1'($urandom);
    sgn[1] = ng;
    tap(3'h7, ng, 2, 2'h2, 2);
    chk(3'h2);
    flg = 3'h2;
    tend("axis select");
    for (int j = 0; j < 5; j++) begin
      cfg(8'h07, en_t[j], lt_t[j]);
      ng = 1'($urandom);
      k = $urandom_range(0, 2);
      m = 3'h1 << k;
      if (b_t[j] != 2'h0) begin
        sgn = 3'h0;
        sgn[k] = ng;
        flg = m;
      end
      tap(m, ng, 2, a_t[j], 2);
      quiet(3);
      tap(m, ng, 2, b_t[j], 2);
      chk(flg);
      tend("enable mode");
    end
    ng = 1'($urandom);
    k = $urandom_range(0, 2);
    m = 3'h1 << k;
    sgn = 3'h0;
    sgn[k] = ng;
    cfg(8'h0F, 8'h60, 8'h02);
    tap(m, ng, 2, 2'h0, 0);
    tap(m, ng, 1, 2'h2, 0);
    quiet(4);
    cfg(8'h07, 8'h60, 8'h02);
    tap(m, ng, 2, 2'h0, 0);
    quiet(2);
    tap(m, ng, 1, 2'h2, 0);
    tap(m, ng, 2, 2'h0, 0);
    quiet(3);
    tap(m, ng, 5, 2'h2, 4);
    chk(m);
    // A double tap with timers at the suggested starting values.
    cfg(8'h07, 8'h60, 8'h11);
    acc(1'h1, ADDR_TAP_MAX_DURATION, 8'h11);
    acc(1'h1, ADDR_TAP_SECOND_WINDOW, 8'h41);
    tap(m, ng, 3, 2'h0, 0);
    quiet(18);
    tap(m, ng, 3, 2'h3, 3);
    chk(m);
    tend("invalid doubles");
    cfg(8'h17, 8'h40, 8'h02);
    tap(m, ~ng, 2, 2'h2, 2);
    sgn[k] = ~ng;
    chk(m);
    tend("improved mode");
    close_out();
  end
endmodule
